/* File: hw/settings_bank_pkg.sv */
// Summary of operation
// - Byte 0 bit 7 set suspends automatic retuning; clear keeps it active unless byte 2 bit 5 is set.
// - Byte 0 bit 6 selects full tuning at 0, partial tuning at 1.
// - Byte 0 bit 5 enables snap detection.
// - Writing 1 to byte 0 bit 4 forces a retune while byte 2 bit 5 is clear, then self-clears.
// - Writing 1 to byte 0 bit 3 reseeds baselines, then self-clears.
// - Byte 0 bit 2 permits streaming during tuning; default on.
// - Writing 1 to byte 1 bit 7 clears reset flag, then self-clears.
// - Byte 1 bit 6 selects 2 MHz at 0, 1 MHz at 1.
// - Byte 1 bit 4 halts all sensing conversions.
// - Byte 1 bit 2 selects self or projected proximity for channel 0.
// - Byte 1 bit 1 forces low power; clears when low power exits.
// - Byte 1 bit 0 sets retune band: eighth or quarter of average.
// - Byte 2 bit 7 makes halt timer expiry enter low power at once.
// - Byte 2 bit 5 freezes all averages and blocks auto-tuning.
// - Byte 2 bit 4 disables raw count filtering.
// - Byte 2 bit 3 disables the serial bus timeout.
// - Byte 2 bit 2 selects streaming at 0, event reporting at 1.
// - Byte 2 bits 1:0 select halt: period, period, never, always.
// - Byte 3 bits 5:4 select tracking divisor 2^5 to 2^8.
// - Byte 3 bit 2 selects one dedicated or all receive electrodes.
// - Byte 3 bit 1 selects absolute or relative coordinates.
// - Byte 3 bit 0 set gives unfiltered XY data.
// - In event mode, each event type is masked by its bit in the event mask.
`default_nettype none
package settings_bank_pkg;
	// ----------------------------------------
	// Group addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_COMP = 8'h07;
	localparam logic [7:0] ADDR_SETTINGS = 8'h08;
	localparam logic [7:0] ADDR_THRESH = 8'h09;
	localparam logic [7:0] ADDR_EVENT_MASK = 8'h0c;
	// ----------------------------------------
	// Group sizes
	// ----------------------------------------
	localparam int NUM_CHANNELS = 13;
	localparam int NUM_SETTINGS = 7;
	localparam logic [3:0] LAST_CH = 4'hc;
	localparam logic [3:0] LAST_SET = 4'h6;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_COMP = 8'h00;
	localparam logic [7:0] RST_SET0 = 8'h06;
	localparam logic [7:0] RST_SET1 = 8'h00;
	localparam logic [7:0] RST_SET2 = 8'h00;
	localparam logic [7:0] RST_SET3 = 8'h06;
	localparam logic [7:0] RST_SET4 = 8'h07;
	localparam logic [7:0] RST_SET5 = 8'h7f;
	localparam logic [7:0] RST_SET6 = 8'h00;
	localparam logic [7:0] RST_TH0 = 8'h04;
	localparam logic [7:0] RST_THN = 8'h10;
	localparam logic [7:0] RST_EVENT_MASK = 8'hff;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int B0_TUNE_OFF = 7;
	localparam int B0_PARTIAL = 6;
	localparam int B0_SNAP = 5;
	localparam int B0_RETUNE = 4;
	localparam int B0_RESEED = 3;
	localparam int B0_STREAM = 2;
	localparam int B1_ACK_RESET = 7;
	localparam int B1_TRANSFER_FREQ_SEL = 6;
	localparam int B1_HALT_CONV = 4;
	localparam int B1_PROX_PROJ = 2;
	localparam int B1_SLEEP = 1;
	localparam int B1_BAND = 0;
	localparam int B2_SLEEP_HALT = 7;
	localparam int B2_WATCHDOG_DISABLE = 6;
	localparam int B2_FREEZE = 5;
	localparam int B2_CNT_FILT_OFF = 4;
	localparam int B2_TIMEOUT_OFF = 3;
	localparam int B2_EVENT_MODE = 2;
	localparam int B3_RX_MULTI = 2;
	localparam int B3_RELATIVE = 1;
	localparam int B3_UNFILTERED = 0;
	// ----------------------------------------
	// Halt selection codes
	// ----------------------------------------
	localparam logic [1:0] HALT_NEVER = 2'h2;
	localparam logic [1:0] HALT_ALWAYS = 2'h3;

	typedef enum logic [1:0] {HALT_PERIOD, HALT_OFF, HALT_ON} halt_mode_type;

	// Byte port from the serial bus engine
	typedef struct packed {
		logic start;
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bus_req_type;

	// Decoded controls toward the sensing core
	typedef struct packed {
		logic tune_disable;
		logic partial_tuning_sel;
		logic snap_enable;
		logic force_retune;
		logic reseed;
		logic stream_during_tuning;
		logic ack_reset;
		logic transfer_freq_sel;
		logic halt_conversions;
		logic prox_projected;
		logic force_sleep;
		logic retune_band_sel;
		logic sleep_on_halt;
		logic watchdog_disable;
		logic freeze_average;
		logic count_filter_disable;
		logic timeout_disable;
		logic event_mode;
		halt_mode_type halt_mode;
		logic [1:0] beta_sel;
		logic rx_multi;
		logic relative_coord;
		logic xy_unfiltered;
		logic [7:0] event_mask;
	} ctrl_type;
endpackage
`default_nettype wire

/* File: hw/touch_sensor_settings_bank.sv */
`default_nettype none
module touch_sensor_settings_bank (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Serial bus byte port
	input wire settings_bank_pkg::bus_req_type bus_req,
	output logic [7:0] rdata,
	// Core status
	input wire logic retune_done,
	input wire logic reseed_done,
	input wire logic reset_acked,
	input wire logic low_power_exit,
	input wire logic halt_timer_expired,
	input wire logic [7:0] raw_events,
	// Decoded controls
	output settings_bank_pkg::ctrl_type ctrl,
	output logic sleep_request,
	output logic [7:0] event_flags
);
	import settings_bank_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [NUM_CHANNELS-1:0][7:0] comp;
		logic [NUM_SETTINGS-1:0][7:0] set;
		logic [NUM_CHANNELS-1:0][7:0] thr;
		logic [7:0] emask;
		logic [7:0] grp;
		logic [3:0] idx;
		logic [7:0] rdata;
		ctrl_type ctrl;
		logic sleep_req;
		logic [7:0] events;
	} state_type;

	state_type state_reg;
	state_type state_next;

	// Reset image of the whole bank
	function automatic state_type reset_state();
		state_type s;
		s = '0;
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			s.comp[i] = RST_COMP;
			s.thr[i] = (i == 0) ? RST_TH0 : RST_THN;
		end
		s.set[0] = RST_SET0;
		s.set[1] = RST_SET1;
		s.set[2] = RST_SET2;
		s.set[3] = RST_SET3;
		s.set[4] = RST_SET4;
		s.set[5] = RST_SET5;
		s.set[6] = RST_SET6;
		s.emask = RST_EVENT_MASK;
		s.ctrl.event_mask = RST_EVENT_MASK;
		// Decoded controls match the reset settings while reset is held
		s.ctrl.stream_during_tuning = RST_SET0[B0_STREAM];
		s.ctrl.rx_multi = RST_SET3[B3_RX_MULTI];
		s.ctrl.relative_coord = RST_SET3[B3_RELATIVE];
		return s;
	endfunction

	// Byte read at the current group and index
	function automatic logic [7:0] read_byte(input state_type s);
		logic [7:0] v;
		v = 8'h00;
		case (s.grp)
			ADDR_COMP: if (s.idx <= LAST_CH) v = s.comp[s.idx];
			ADDR_SETTINGS: if (s.idx <= LAST_SET) v = s.set[s.idx];
			ADDR_THRESH: if (s.idx <= LAST_CH) v = s.thr[s.idx];
			ADDR_EVENT_MASK: if (s.idx == 4'h0) v = s.emask;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [7:0] b3;
		state_next = state_reg;
		// Address phase selects group and restarts at byte 0
		if (bus_req.start) begin
			state_next.grp = bus_req.addr;
			state_next.idx = 4'h0;
		end else if (bus_req.wr) begin
			case (state_reg.grp)
				ADDR_COMP: if (state_reg.idx <= LAST_CH)
					state_next.comp[state_reg.idx] = bus_req.wdata;
				ADDR_SETTINGS: if (state_reg.idx <= LAST_SET)
					state_next.set[state_reg.idx] = bus_req.wdata;
				ADDR_THRESH: if (state_reg.idx <= LAST_CH)
					state_next.thr[state_reg.idx] = bus_req.wdata;
				ADDR_EVENT_MASK: if (state_reg.idx == 4'h0)
					state_next.emask = bus_req.wdata;
				default: ;
			endcase
			// Writing 0 to a command bit leaves a pending command alone
			if (state_reg.grp == ADDR_SETTINGS && state_reg.idx == 4'h0) begin
				state_next.set[0][B0_RETUNE] = state_reg.set[0][B0_RETUNE]
					| bus_req.wdata[B0_RETUNE];
				state_next.set[0][B0_RESEED] = state_reg.set[0][B0_RESEED]
					| bus_req.wdata[B0_RESEED];
			end
			if (state_reg.grp == ADDR_SETTINGS && state_reg.idx == 4'h1) begin
				state_next.set[1][B1_ACK_RESET] = state_reg.set[1][B1_ACK_RESET]
					| bus_req.wdata[B1_ACK_RESET];
				state_next.set[1][B1_SLEEP] = state_reg.set[1][B1_SLEEP]
					| bus_req.wdata[B1_SLEEP];
			end
			// Index saturates so a long burst never wraps back to byte 0
			if (state_reg.idx != 4'hf) begin
				state_next.idx = state_reg.idx + 4'h1;
			end
		end else if (bus_req.rd) begin
			if (state_reg.idx != 4'hf) begin
				state_next.idx = state_reg.idx + 4'h1;
			end
		end
		// Self-clearing command bits; a same-cycle write of 1 keeps them set
		if (retune_done && !(bus_req.wr && bus_req.wdata[B0_RETUNE]
			&& state_reg.grp == ADDR_SETTINGS && state_reg.idx == 4'h0))
			state_next.set[0][B0_RETUNE] = 1'b0;
		if (reseed_done && !(bus_req.wr && bus_req.wdata[B0_RESEED]
			&& state_reg.grp == ADDR_SETTINGS && state_reg.idx == 4'h0))
			state_next.set[0][B0_RESEED] = 1'b0;
		if (reset_acked && !(bus_req.wr && bus_req.wdata[B1_ACK_RESET]
			&& state_reg.grp == ADDR_SETTINGS && state_reg.idx == 4'h1))
			state_next.set[1][B1_ACK_RESET] = 1'b0;
		if (low_power_exit && !(bus_req.wr && bus_req.wdata[B1_SLEEP]
			&& state_reg.grp == ADDR_SETTINGS && state_reg.idx == 4'h1))
			state_next.set[1][B1_SLEEP] = 1'b0;
		// Read data for the byte now addressed
		state_next.rdata = read_byte(state_next);
		// Decode controls from the settings bytes
		b0 = state_next.set[0];
		b1 = state_next.set[1];
		b2 = state_next.set[2];
		b3 = state_next.set[3];
		state_next.ctrl.tune_disable = b0[B0_TUNE_OFF] | b2[B2_FREEZE];
		state_next.ctrl.partial_tuning_sel = b0[B0_PARTIAL];
		state_next.ctrl.snap_enable = b0[B0_SNAP];
		state_next.ctrl.force_retune = b0[B0_RETUNE] & ~b2[B2_FREEZE];
		state_next.ctrl.reseed = b0[B0_RESEED];
		state_next.ctrl.stream_during_tuning = b0[B0_STREAM];
		state_next.ctrl.ack_reset = b1[B1_ACK_RESET];
		state_next.ctrl.transfer_freq_sel = b1[B1_TRANSFER_FREQ_SEL];
		state_next.ctrl.halt_conversions = b1[B1_HALT_CONV];
		state_next.ctrl.prox_projected = b1[B1_PROX_PROJ];
		state_next.ctrl.force_sleep = b1[B1_SLEEP];
		state_next.ctrl.retune_band_sel = b1[B1_BAND];
		state_next.ctrl.sleep_on_halt = b2[B2_SLEEP_HALT];
		state_next.ctrl.watchdog_disable = b2[B2_WATCHDOG_DISABLE];
		state_next.ctrl.freeze_average = b2[B2_FREEZE];
		state_next.ctrl.count_filter_disable = b2[B2_CNT_FILT_OFF];
		state_next.ctrl.timeout_disable = b2[B2_TIMEOUT_OFF];
		state_next.ctrl.event_mode = b2[B2_EVENT_MODE];
		case (b2[1:0])
			HALT_NEVER: state_next.ctrl.halt_mode = HALT_OFF;
			HALT_ALWAYS: state_next.ctrl.halt_mode = HALT_ON;
			default: state_next.ctrl.halt_mode = HALT_PERIOD;
		endcase
		state_next.ctrl.beta_sel = b3[5:4];
		state_next.ctrl.rx_multi = b3[B3_RX_MULTI];
		state_next.ctrl.relative_coord = b3[B3_RELATIVE];
		state_next.ctrl.xy_unfiltered = b3[B3_UNFILTERED];
		state_next.ctrl.event_mask = state_next.emask;
		// Sleep request: forced, or halt timer expiry with sleep-on-halt
		state_next.sleep_req = b1[B1_SLEEP]
			| (b2[B2_SLEEP_HALT] & halt_timer_expired);
		// Only unmasked event types are reported in event mode
		state_next.events = b2[B2_EVENT_MODE]
			? (raw_events & state_next.emask) : raw_events;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= reset_state();
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from the state register
	assign rdata = state_reg.rdata;
	assign ctrl = state_reg.ctrl;
	assign sleep_request = state_reg.sleep_req;
	assign event_flags = state_reg.events;
endmodule
`default_nettype wire

/* File: sim/settings_bank_props.sv */
`default_nettype none
module settings_bank_props (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Bus side
	input wire settings_bank_pkg::bus_req_type bus_req,
	input wire logic [7:0] rdata,
	// Core side
	input wire logic retune_done,
	input wire logic reseed_done,
	input wire logic reset_acked,
	input wire logic low_power_exit,
	input wire logic halt_timer_expired,
	input wire logic [7:0] raw_events,
	input wire settings_bank_pkg::ctrl_type ctrl,
	input wire logic sleep_request,
	input wire logic [7:0] event_flags
);
	import settings_bank_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ----
	// Command bits, decode and outputs
	// ----
	chk_retune_self_clear: assert property (retune_done && !bus_req.wr |=> !ctrl.force_retune)
		else $error("retune bit stuck");
	chk_reseed_self_clear: assert property (reseed_done && !bus_req.wr |=> !ctrl.reseed)
		else $error("reseed bit stuck");
	chk_ack_self_clear: assert property (reset_acked && !bus_req.wr |=> !ctrl.ack_reset)
		else $error("reset ack bit stuck");
	chk_sleep_exit_clear: assert property (low_power_exit && !bus_req.wr |=> !ctrl.force_sleep)
		else $error("sleep bit stuck");
	chk_freeze_blocks_tune: assert property (ctrl.freeze_average |-> ctrl.tune_disable && !ctrl.force_retune)
		else $error("tuning while frozen");
	chk_halt_sleep_now: assert property (ctrl.sleep_on_halt && halt_timer_expired && !bus_req.wr |=> sleep_request)
		else $error("no sleep on halt expiry");
	chk_sleep_idle_low: assert property (!ctrl.force_sleep && !halt_timer_expired && !bus_req.wr |=> !sleep_request)
		else $error("sleep without cause");
	chk_event_mask_apply: assert property (!bus_req.wr |=> event_flags == ($past(ctrl.event_mode) ?
		$past(raw_events) & $past(ctrl.event_mask) : $past(raw_events)))
		else $error("event flags wrong");
	chk_gap_reads_zero: assert property (bus_req.start && bus_req.addr == 8'h0a |=> rdata == 8'h00)
		else $error("unmapped group not zero");
	cover property (ctrl.force_retune ##1 !ctrl.force_retune);
	cover property (sleep_request && !ctrl.force_sleep);
	cover property (ctrl.event_mode && event_flags != raw_events);
endmodule
bind touch_sensor_settings_bank settings_bank_props settings_bank_props_inst (.clk_sys, .rst_n,
	.bus_req, .rdata, .retune_done, .reseed_done, .reset_acked, .low_power_exit,
	.halt_timer_expired, .raw_events, .ctrl, .sleep_request, .event_flags);
`default_nettype wire

/* File: sim/host_model.sv */
`default_nettype none
module host_model (
	// Clock
	input wire logic clk_sys,
	// Byte port toward the bank
	output var settings_bank_pkg::bus_req_type bus_req
);
	timeunit 1ns;
	timeprecision 1ps;
	initial bus_req = '0;
	// One strobe set after an edge, held until the next edge takes it
	task automatic put(input logic s, w, r, input logic [7:0] a, d);
		@(posedge clk_sys);
		bus_req <= '{s, w, r, a, d};
		@(negedge clk_sys);
	endtask
	task automatic go(input logic [7:0] a); put(1, 0, 0, a, ~bus_req.wdata); endtask
	task automatic wr(input logic [7:0] d); put(0, 1, 0, ~bus_req.addr, d); endtask
	task automatic rd(); put(0, 0, 1, ~bus_req.addr, ~bus_req.wdata); endtask
	// Released lines flip so stale values never look valid
	task automatic idle(); put(0, 0, 0, ~bus_req.addr, ~bus_req.wdata); endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import settings_bank_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] done_v = 4'h0;
	logic halt_exp = 1'b0;
	logic [7:0] raw_ev = 8'h00;
	bus_req_type bus_req;
	logic [7:0] rdata;
	ctrl_type ctrl;
	logic sleep_request;
	logic [7:0] event_flags;
	logic [7:0] exp [14];
	logic [7:0] p;
	halt_mode_type hm;
	int num_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	// ----
	// Clock, host and design
	// ----
	always #10 clk_sys = ~clk_sys;
	host_model host_model_inst (.clk_sys, .bus_req);
	touch_sensor_settings_bank touch_sensor_settings_bank_inst (.clk_sys, .rst_n, .bus_req, .rdata,
		.retune_done(done_v[0]), .reseed_done(done_v[1]), .reset_acked(done_v[2]),
		.low_power_exit(done_v[3]), .halt_timer_expired(halt_exp), .raw_events(raw_ev),
		.ctrl, .sleep_request, .event_flags);
	// Cut a hang short
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		n_compared++;
		if (got !== want) begin
			$display("[FAIL] %0t got %h want %h", $time, got, want);
			num_errors++;
		end
	endtask
	// Read n bytes against exp, then one past the group end
	task automatic rdall(input logic [7:0] a, input int n);
		host_model_inst.go(a);
		for (int i = 0; i <= n; i++) begin
			host_model_inst.rd();
			chk(rdata, (i < n) ? exp[i] : 8'h00);
		end
		host_model_inst.idle();
	endtask
	task automatic wrall(input logic [7:0] a, input int n);
		host_model_inst.go(a);
		for (int i = 0; i < n; i++) host_model_inst.wr(exp[i]);
		host_model_inst.idle();
	endtask
	task automatic pulse(input int k);
		@(posedge clk_sys);
		done_v <= 4'h1 << k;
		@(posedge clk_sys);
		done_v <= 4'h0;
		@(negedge clk_sys);
	endtask
	// Main sequence
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		exp = '{default: 8'h00};
		rdall(ADDR_COMP, 13);
		exp = '{0: 8'h06, 3: 8'h06, 4: 8'h07, 5: 8'h7f, default: 8'h00};
		rdall(ADDR_SETTINGS, 7);
		exp = '{0: 8'h04, default: 8'h10};
		rdall(ADDR_THRESH, 13);
		exp = '{0: 8'hff, default: 8'h00};
		rdall(ADDR_EVENT_MASK, 1);
		wrall(8'h0a, 1);
		rdall(8'h0a, 0);
		for (int i = 0; i < 14; i++) exp[i] = 8'(i * 37 + 5);
		for (int g = 0; g < 2; g++) begin
			wrall(g ? ADDR_COMP : ADDR_THRESH, 14);
			rdall(g ? ADDR_COMP : ADDR_THRESH, 13);
		end
		// Every non-command field and halt code, both polarities
		for (int i = 3; i >= 0; i--) begin
			p = i[0] ? 8'ha5 : 8'h5a;
			hm = (i < 2) ? HALT_PERIOD : (i == 2) ? HALT_OFF : HALT_ON;
			exp = '{0: p & 8'he7, 1: p & 8'h75, 2: {p[7:2], i[1:0]},
				3: {2'b00, i[1:0], 1'b0, p[2:0]}, 4: p, 5: ~p, 6: p, default: 8'h00};
			wrall(ADDR_SETTINGS, 7);
			rdall(ADDR_SETTINGS, 7);
			chk({ctrl.tune_disable, ctrl.partial_tuning_sel, ctrl.snap_enable,
				ctrl.stream_during_tuning, ctrl.transfer_freq_sel, ctrl.halt_conversions,
				ctrl.prox_projected, ctrl.retune_band_sel}, {exp[0][7] | exp[2][5], exp[0][6],
				exp[0][5], exp[0][2], exp[1][6], exp[1][4], exp[1][2], exp[1][0]});
			chk({ctrl.sleep_on_halt, ctrl.watchdog_disable, ctrl.freeze_average,
				ctrl.count_filter_disable, ctrl.timeout_disable, ctrl.event_mode, ctrl.rx_multi,
				ctrl.relative_coord}, {exp[2][7:2], exp[3][2:1]});
			chk({ctrl.xy_unfiltered, ctrl.beta_sel, hm == ctrl.halt_mode}, {exp[3][0], i[1:0], 1'b1});
		end
		// Command bits stick until the core reports done
		exp = '{0: 8'h18, 1: 8'h82, default: 8'h00};
		wrall(ADDR_SETTINGS, 2);
		exp = '{default: 8'h00};
		wrall(ADDR_SETTINGS, 2);
		chk({ctrl.force_retune, ctrl.reseed, ctrl.ack_reset, ctrl.force_sleep, sleep_request}, 8'h1f);
		for (int k = 0; k < 4; k++) begin
			pulse(k);
			chk({ctrl.force_retune, ctrl.reseed, ctrl.ack_reset, ctrl.force_sleep}, 8'h0f >> (k + 1));
		end
		chk(sleep_request, 8'h00);
		rdall(ADDR_SETTINGS, 0);
		// Halt expiry sleep and event masking
		exp = '{0: 8'h0f, default: 8'h00};
		wrall(ADDR_EVENT_MASK, 1);
		exp = '{2: 8'h84, default: 8'h00};
		wrall(ADDR_SETTINGS, 3);
		@(posedge clk_sys);
		halt_exp <= 1'b1;
		raw_ev <= 8'ha5;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		chk({sleep_request, event_flags[6:0]}, 8'h85);
		@(posedge clk_sys);
		halt_exp <= 1'b0;
		exp = '{default: 8'h00};
		wrall(ADDR_SETTINGS, 3);
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk(event_flags, 8'ha5);
		chk(sleep_request, 8'h00);
		// Reset in mid-run restores the image and its decoded controls
		@(posedge clk_sys);
		raw_ev <= 8'h00;
		rst_n <= 1'b0;
		@(negedge clk_sys);
		chk({ctrl.stream_during_tuning, ctrl.rx_multi, ctrl.relative_coord, sleep_request,
			event_flags[3:0]}, 8'he0);
		@(posedge clk_sys);
		rst_n <= 1'b1;
		exp = '{0: 8'h06, 3: 8'h06, 4: 8'h07, 5: 8'h7f, default: 8'h00};
		rdall(ADDR_SETTINGS, 7);
		chk({ctrl.stream_during_tuning, ctrl.rx_multi, ctrl.relative_coord}, 8'h07);
		exp = '{0: 8'hff, default: 8'h00};
		rdall(ADDR_EVENT_MASK, 1);
		stop_test();
	end
endmodule
`default_nettype wire
